// File: apb_host_model.sv
// Purpose: apb master standing for the software side
// Assumes: signals change only right after a rising edge
// Notes:   released write data is inverted, never left at old value
`timescale 1ns/1ps
module apb_host_model (
    // clock
    input wire logic        pclk,
    // request
    output logic            psel,
    output logic            penable,
    output logic            pwrite,
    output logic [7:0]      paddr,
    output logic [31:0]     pwdata,
    // answer
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e, output logic t);
        int n;
        t = 1'b1;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16 && t; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) begin
                q = prdata;
                e = pslverr;
                t = 1'b0;
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask : xfer
endmodule : apb_host_model

// File: byte_mem.sv
// Purpose: small byte memory with registered read data
// Assumes: read of the address being written returns the old byte
// Notes:   contents are not reset
`timescale 1ns/1ps
module byte_mem #(
    parameter int AW = 5
) (
    // clock
    input  wire logic pclk,
    // port
    mem_if.mem        port
);
    logic [7:0] store [0:(1<<AW)-1];

    always_ff @(posedge pclk) begin
        if (port.we) begin
            store[port.waddr] <= port.wdata;
        end
    end

    always_ff @(posedge pclk) begin
        port.rdata <= store[port.raddr];
    end
endmodule : byte_mem

// File: exec_map.svh
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: 32-bit apb data, one aligned word per register
// Notes:   definitions only
`ifndef EXEC_MAP_SVH
`define EXEC_MAP_SVH

// ***********************
// register offsets
// ***********************
`define OFS_INSTR      8'h00
`define OFS_STATUS     8'h04
`define OFS_FLAGS      8'h08
`define OFS_PC         8'h0C
`define OFS_GPR_ADDR   8'h10
`define OFS_GPR_DATA   8'h14
`define OFS_IO_ADDR    8'h18
`define OFS_IO_DATA    8'h1C

// ***********************
// instruction word fields
// ***********************
`define INSTR_OP_LSB   0
`define INSTR_ADR_LSB  4
`define INSTR_BIT_LSB  9
`define INSTR_K_LSB    12

// ***********************
// status flag positions
// ***********************
`define FLAG_C         0
`define FLAG_Z         1
`define FLAG_N         2
`define FLAG_V         3
`define FLAG_T         6
`define FLAG_I         7

// ***********************
// status register fields
// ***********************
`define STAT_BUSY      0
`define STAT_CYC_LSB   4

// ***********************
// reset values and cycle counts
// ***********************
`define FLAGS_RST      8'h00
`define PC_RST         16'h0000
`define CYC_BRANCH_NT  2'h1
`define CYC_BRANCH_TK  2'h2
`define CYC_IO_BIT     2'h2
`define CYC_SHIFT      2'h1

`endif

// File: exec_pkg.sv
// Purpose: types shared by the executer
// Assumes: nothing
// Notes:   operation codes are the low nibble of the instruction word
package exec_pkg;

    typedef enum logic [3:0] {
        branch_on_transfer_bit_clear = 4'h0,
        branch_on_overflow_set       = 4'h1,
        branch_on_overflow_clear     = 4'h2,
        branch_if_irq_enabled        = 4'h3,
        branch_if_irq_disabled       = 4'h4,
        io_bit_set_op                = 4'h5,
        io_bit_clear_op              = 4'h6,
        logical_left_shift_op        = 4'h7,
        logical_right_shift_op       = 4'h8
    } op_t;

    typedef enum logic [3:0] {
        st_idle   = 4'b0001,
        st_exec   = 4'b0010,
        st_branch = 4'b0100,
        st_bitwr  = 4'b1000
    } state_t;

endpackage : exec_pkg

// File: exec_properties.sv
// Purpose: port-level checks of the flag branch executer
// Assumes: one wait state apb, one instruction at a time
// Notes:   bound to the top module at the foot
`timescale 1ns/1ps
`include "exec_map.svh"
module exec_checker #(
    parameter int PC_W = 16,
    parameter int K_W  = 7
) (
    // clock and reset
    input wire logic            pclk,
    input wire logic            presetn,
    // apb
    input wire logic            psel,
    input wire logic            penable,
    input wire logic            pwrite,
    input wire logic [7:0]      paddr,
    input wire logic [31:0]     pwdata,
    input wire logic [31:0]     prdata,
    input wire logic            pready,
    input wire logic            pslverr,
    // core state
    input wire logic [PC_W-1:0] pc,
    input wire logic [7:0]      flags,
    input wire logic            busy
);
    logic            wr_ok;
    logic            iw;
    logic            br;
    logic            tk;
    logic [3:0]      op;
    logic [PC_W-1:0] tgt_reg;
    logic [PC_W-1:0] nt_reg;
    assign wr_ok = psel && penable && pready && pwrite && !pslverr;
    assign op = pwdata[3:0];
    assign iw = wr_ok && paddr == `OFS_INSTR;
    assign br = iw && op <= 4'h4;
    always_comb begin
        case (op)
            4'h0: tk = !flags[`FLAG_T];
            4'h1: tk = flags[`FLAG_V];
            4'h2: tk = !flags[`FLAG_V];
            4'h3: tk = flags[`FLAG_I];
            default: tk = !flags[`FLAG_I];
        endcase
    end
    // targets frozen at issue, pc moves later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tgt_reg <= '0;
            nt_reg <= '0;
        end else if (br) begin
            tgt_reg <= pc + PC_W'($signed(pwdata[`INSTR_K_LSB +: K_W])) + 1'b1;
            nt_reg <= pc + 1'b1;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_wait: assert property (psel && penable && $past(psel && !penable) |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside answer");
    a_branch_taken: assert property (br && tk |=> busy ##1 busy ##1 (!busy && pc == tgt_reg))
        else $error("taken branch wrong target or length");
    a_branch_fall: assert property (br && !tk |=> busy ##1 (!busy && pc == nt_reg))
        else $error("failed branch wrong pc or length");
    a_flags_kept: assert property (iw && op <= 4'h6 |=> $stable(flags)[*3])
        else $error("flags changed by branch or bit op");
    a_io_two: assert property (iw && (op == 4'h5 || op == 4'h6) |=> busy[*2] ##1 !busy)
        else $error("bit op not two cycles");
    a_shift_flags: assert property (iw && (op == 4'h7 || op == 4'h8) |=> busy ##1 (!busy
        && flags[`FLAG_V] == (flags[`FLAG_N] ^ flags[`FLAG_C]) && flags[7:4] == $past(flags[7:4], 2)))
        else $error("shift flags or length wrong");
    a_pc_hold: assert property (!busy && !(wr_ok && paddr == `OFS_PC) |=> $stable(pc))
        else $error("pc moved while idle");
    a_status_ro: assert property (psel && penable && pready && pwrite && paddr == `OFS_STATUS |-> pslverr)
        else $error("status write not refused");
    c_taken: cover property (br && tk);
    c_refused: cover property (pready && pslverr);
    c_shift: cover property (iw && op == 4'h8);
endmodule : exec_checker
bind flag_branch_bitio_shift_exec exec_checker #(.PC_W(PC_W), .K_W(K_W)) chk (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pc, .flags, .busy);

// File: flag_branch_bitio_shift_exec.sv
// Purpose: executes flag branches, i/o bit set/clear and logical shifts
// Assumes: apb master holds each request until pready; one instruction at a time
// Notes:   software issues an instruction by writing the instruction word
//
// Summary of operation
// - When the transfer bit is clear the transfer-clear branch sets pc to pc plus offset plus one, flags kept.
// - The overflow-set branch jumps to pc plus offset plus one only when the overflow flag is one.
// - The overflow-clear branch jumps to pc plus offset plus one when the overflow flag is zero.
// - The interrupts-enabled branch jumps to pc plus offset plus one when the global interrupt flag is one.
// - The interrupts-disabled branch jumps to pc plus offset plus one when the global interrupt flag is zero.
// - The i/o bit set forces the chosen bit to one, keeps all else, and takes two cycles.
// - The i/o bit clear forces the chosen bit to zero, keeps all else, and takes two cycles.
// - The left shift moves bits up, fills bit zero with zero and sets zero, carry, negative, overflow in one cycle.
// - The right shift moves bits down, fills bit seven with zero and sets the same four flags in one cycle.
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "exec_map.svh"
module flag_branch_bitio_shift_exec #(
    parameter int PC_W = 16,
    parameter int K_W  = 7
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // core state
    output logic [PC_W-1:0]  pc,
    output logic [7:0]       flags,
    output logic             busy
);
    // ***********************
    // declarations
    // ***********************
    exec_pkg::state_t state_reg;
    logic [31:0]      instr_reg;
    logic [PC_W-1:0]  pc_reg;
    logic [7:0]       flags_reg;
    logic [4:0]       gpr_addr_reg;
    logic [4:0]       io_addr_reg;
    logic [1:0]       cyc_reg;
    logic [1:0]       cyc_last_reg;
    logic [7:0]       bit_val_reg;
    logic [31:0]      prdata_reg;
    logic             pready_reg;
    logic             pslverr_reg;
    logic             busy_reg;
    logic             access;
    logic             done;
    logic             bad;
    logic             issue;
    logic             cond;
    logic [7:0]       shifted;
    logic             carry_out;
    logic [PC_W-1:0]  target;
    logic [31:0]      rd_mux;
    exec_pkg::op_t    op;

    mem_if #(.AW(5)) gpr_port ();
    mem_if #(.AW(5)) io_port ();

    byte_mem #(.AW(5)) u_gpr (.pclk(pclk), .port(gpr_port));
    byte_mem #(.AW(5)) u_io  (.pclk(pclk), .port(io_port));

    // ***********************
    // decode helpers
    // ***********************
    function automatic logic legal_op(input logic [3:0] code);
        legal_op = (code <= 4'(exec_pkg::logical_right_shift_op));
    endfunction : legal_op

    function automatic logic is_branch(input exec_pkg::op_t code);
        is_branch = (code <= exec_pkg::branch_if_irq_disabled);
    endfunction : is_branch

    function automatic logic is_shift(input exec_pkg::op_t code);
        is_shift = (code == exec_pkg::logical_left_shift_op) || (code == exec_pkg::logical_right_shift_op);
    endfunction : is_shift

    assign op        = exec_pkg::op_t'(instr_reg[`INSTR_OP_LSB +: 4]);
    assign access    = psel && penable;
    // one wait state on every transfer so memory reads land in time
    assign done      = access && pready_reg;
    assign issue     = done && pwrite && !bad && (paddr == `OFS_INSTR);

    always_comb begin
        bad = 1'b0;
        unique case (paddr)
            `OFS_INSTR:                     bad = pwrite && (busy || !legal_op(pwdata[`INSTR_OP_LSB +: 4]));
            `OFS_STATUS:                    bad = pwrite;
            `OFS_FLAGS, `OFS_PC:            bad = pwrite && busy;
            `OFS_GPR_ADDR, `OFS_IO_ADDR:    bad = 1'b0;
            `OFS_GPR_DATA, `OFS_IO_DATA:    bad = busy;
            default:                        bad = 1'b1;
        endcase
    end

    // ***********************
    // execution datapath
    // ***********************
    always_comb begin
        unique case (op)
            exec_pkg::branch_on_transfer_bit_clear: cond = !flags_reg[`FLAG_T];
            exec_pkg::branch_on_overflow_set:       cond = flags_reg[`FLAG_V];
            exec_pkg::branch_on_overflow_clear:     cond = !flags_reg[`FLAG_V];
            exec_pkg::branch_if_irq_enabled:        cond = flags_reg[`FLAG_I];
            exec_pkg::branch_if_irq_disabled:       cond = !flags_reg[`FLAG_I];
            default:                                cond = 1'b0;
        endcase
    end

    // signed offset, sign extended to pc width
    assign target = PC_W'(pc_reg + {{(PC_W-K_W){instr_reg[`INSTR_K_LSB+K_W-1]}},
                                    instr_reg[`INSTR_K_LSB +: K_W]} + PC_W'(1));

    always_comb begin
        if (op == exec_pkg::logical_left_shift_op) begin
            shifted   = {gpr_port.rdata[6:0], 1'b0};
            carry_out = gpr_port.rdata[7];
        end else begin
            shifted   = {1'b0, gpr_port.rdata[7:1]};
            carry_out = gpr_port.rdata[0];
        end
    end

    // ***********************
    // memory ports
    // ***********************
    // operand read is launched on the issuing edge so execution sees it at once
    always_comb begin
        gpr_port.raddr = issue ? pwdata[`INSTR_ADR_LSB +: 5]
                       : (busy ? instr_reg[`INSTR_ADR_LSB +: 5] : gpr_addr_reg);
        io_port.raddr  = issue ? pwdata[`INSTR_ADR_LSB +: 5]
                       : (busy ? instr_reg[`INSTR_ADR_LSB +: 5] : io_addr_reg);
        gpr_port.we    = 1'b0;
        gpr_port.waddr = gpr_addr_reg;
        gpr_port.wdata = pwdata[7:0];
        io_port.we     = 1'b0;
        io_port.waddr  = io_addr_reg;
        io_port.wdata  = pwdata[7:0];
        if (state_reg == exec_pkg::st_exec && is_shift(op)) begin
            gpr_port.we    = 1'b1;
            gpr_port.waddr = instr_reg[`INSTR_ADR_LSB +: 5];
            gpr_port.wdata = shifted;
        end else if (done && pwrite && !bad && paddr == `OFS_GPR_DATA) begin
            gpr_port.we    = 1'b1;
        end
        if (state_reg == exec_pkg::st_bitwr) begin
            io_port.we     = 1'b1;
            io_port.waddr  = instr_reg[`INSTR_ADR_LSB +: 5];
            io_port.wdata  = bit_val_reg;
        end else if (done && pwrite && !bad && paddr == `OFS_IO_DATA) begin
            io_port.we     = 1'b1;
        end
    end

    // ***********************
    // sequencer
    // ***********************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= exec_pkg::st_idle;
            busy_reg  <= 1'b0;
        end else begin
            busy_reg  <= (state_reg == exec_pkg::st_idle) ? issue
                         : (state_reg == exec_pkg::st_exec) && !is_shift(op) && (!is_branch(op) || cond);
            unique case (state_reg)
                exec_pkg::st_idle: begin
                    if (issue) begin
                        state_reg <= exec_pkg::st_exec;
                    end
                end
                exec_pkg::st_exec: begin
                    if (is_branch(op)) begin
                        state_reg <= cond ? exec_pkg::st_branch : exec_pkg::st_idle;
                    end else if (is_shift(op)) begin
                        state_reg <= exec_pkg::st_idle;
                    end else begin
                        state_reg <= exec_pkg::st_bitwr;
                    end
                end
                exec_pkg::st_branch: state_reg <= exec_pkg::st_idle;
                exec_pkg::st_bitwr:  state_reg <= exec_pkg::st_idle;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_reg <= 32'h0000_0000;
        end else if (issue) begin
            instr_reg <= pwdata;
        end
    end

    // read-modify-write keeps the other bits of the i/o byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_val_reg <= 8'h00;
        end else if (state_reg == exec_pkg::st_exec) begin
            bit_val_reg <= io_port.rdata;
            bit_val_reg[instr_reg[`INSTR_BIT_LSB +: 3]] <= (op == exec_pkg::io_bit_set_op);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_reg <= `PC_RST;
        end else if (done && pwrite && !bad && paddr == `OFS_PC) begin
            pc_reg <= pwdata[PC_W-1:0];
        end else if (state_reg == exec_pkg::st_branch) begin
            pc_reg <= target;
        end else if (state_reg == exec_pkg::st_exec && is_branch(op) && !cond) begin
            pc_reg <= PC_W'(pc_reg + PC_W'(1));
        end
    end

    // branches and i/o bit ops never touch the flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_reg <= `FLAGS_RST;
        end else if (done && pwrite && !bad && paddr == `OFS_FLAGS) begin
            flags_reg <= pwdata[7:0];
        end else if (state_reg == exec_pkg::st_exec && is_shift(op)) begin
            flags_reg[`FLAG_C] <= carry_out;
            flags_reg[`FLAG_Z] <= (shifted == 8'h00);
            flags_reg[`FLAG_N] <= shifted[7];
            flags_reg[`FLAG_V] <= shifted[7] ^ carry_out;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc_reg      <= 2'h0;
            cyc_last_reg <= 2'h0;
        end else if (state_reg == exec_pkg::st_idle) begin
            cyc_reg      <= 2'h0;
        end else if ((state_reg == exec_pkg::st_exec && !(is_branch(op) && cond) && is_branch(op))
                     || (state_reg == exec_pkg::st_exec && is_shift(op))
                     || state_reg == exec_pkg::st_branch || state_reg == exec_pkg::st_bitwr) begin
            cyc_last_reg <= 2'(cyc_reg + 2'h1);
            cyc_reg      <= 2'(cyc_reg + 2'h1);
        end else begin
            cyc_reg      <= 2'(cyc_reg + 2'h1);
        end
    end

    // ***********************
    // apb slave
    // ***********************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gpr_addr_reg <= 5'h00;
            io_addr_reg  <= 5'h00;
        end else if (done && pwrite && !bad) begin
            if (paddr == `OFS_GPR_ADDR) begin
                gpr_addr_reg <= pwdata[4:0];
            end
            if (paddr == `OFS_IO_ADDR) begin
                io_addr_reg <= pwdata[4:0];
            end
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            `OFS_INSTR:    rd_mux = instr_reg;
            `OFS_STATUS:   rd_mux = {26'h0, cyc_last_reg, 3'h0, busy};
            `OFS_FLAGS:    rd_mux = {24'h0, flags_reg};
            `OFS_PC:       rd_mux = 32'(pc_reg);
            `OFS_GPR_ADDR: rd_mux = {27'h0, gpr_addr_reg};
            `OFS_GPR_DATA: rd_mux = {24'h0, gpr_port.rdata};
            `OFS_IO_ADDR:  rd_mux = {27'h0, io_addr_reg};
            `OFS_IO_DATA:  rd_mux = {24'h0, io_port.rdata};
            default:       rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end else begin
            pready_reg  <= access && !pready_reg;
            pslverr_reg <= access && !pready_reg && bad;
            prdata_reg  <= (access && !pready_reg && !pwrite && !bad) ? rd_mux : 32'h0000_0000;
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;
    assign pc      = pc_reg;
    assign flags   = flags_reg;
    assign busy    = busy_reg;
endmodule : flag_branch_bitio_shift_exec

// File: flag_branch_bitio_shift_exec_test.sv
// Purpose: register level test of the flag branch executer
// Assumes: apb host model drives the bus
// Notes:   software sets pc and flags before each branch
`timescale 1ns/1ps
`include "exec_map.svh"
module flag_branch_bitio_shift_exec_test;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [15:0] pc;
    logic [7:0]  flags;
    logic        busy;
    int          n_errors;
    int          n_tests;
    logic [7:0]  fl;
    logic [4:0]  want;
    flag_branch_bitio_shift_exec uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .pc, .flags, .busy);
    apb_host_model host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        n_tests++;
        if (s !== x) begin
            n_errors++;
            $display("mismatch at %0t: saw %h want %h", $time, s, x);
        end
    endtask : chk
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                       input logic xe);
        logic e;
        logic t;
        host.xfer(w, a, d, q, e, t);
        if (t) begin
            n_errors++;
            print_verdict;
        end
        chk({31'h0, e}, {31'h0, xe});
    endtask : acc
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] q;
        acc(1'b0, a, 32'h0, q, 1'b0);
        chk(q, x);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic xe);
        logic [31:0] q;
        acc(1'b1, a, d, q, xe);
    endtask : wr
    // issue, poll busy with a bound, then check the cycle count
    task automatic run(input logic [31:0] ins, input logic [1:0] cyc);
        logic [31:0] q;
        int n;
        wr(`OFS_INSTR, ins, 1'b0);
        q = 32'h1;
        for (n = 0; n < 10 && q[0] !== 1'b0; n++)
            acc(1'b0, `OFS_STATUS, 32'h0, q, 1'b0);
        if (q[0] !== 1'b0) begin
            n_errors++;
            print_verdict;
        end
        chk({31'h0, busy}, 32'h0);
        chk({30'h0, q[5:4]}, {30'h0, cyc});
    endtask : run
    initial begin
        presetn = 1'b0;
        n_errors = 0;
        n_tests = 0;
        want = 5'b01010;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(`OFS_PC, 32'h0);
        rd(`OFS_FLAGS, 32'h0);
        // ****************
        // branches, both outcomes, negative offset
        // ****************
        for (int i = 0; i < 5; i++) begin
            for (int t = 0; t < 2; t++) begin
                fl = ((t == 1) == want[i]) ? 8'hCD : 8'h32;
                wr(`OFS_FLAGS, {24'h0, fl}, 1'b0);
                wr(`OFS_PC, 32'h40, 1'b0);
                run({13'h0, 7'h7D, 8'h00, 4'(i)}, (t == 1) ? `CYC_BRANCH_TK : `CYC_BRANCH_NT);
                rd(`OFS_PC, (t == 1) ? 32'h3E : 32'h41);
                chk({16'h0, pc}, (t == 1) ? 32'h3E : 32'h41);
                rd(`OFS_FLAGS, {24'h0, fl});
                chk({24'h0, flags}, {24'h0, fl});
            end
        end
        $display("branch test done");
        // ****************
        // i/o bit set and clear
        // ****************
        wr(`OFS_IO_ADDR, 32'h5, 1'b0);
        wr(`OFS_IO_DATA, 32'hA5, 1'b0);
        wr(`OFS_FLAGS, 32'h5A, 1'b0);
        run({20'h0, 3'h1, 5'h05, 4'h5}, `CYC_IO_BIT);
        rd(`OFS_IO_DATA, 32'hA7);
        run({20'h0, 3'h7, 5'h05, 4'h6}, `CYC_IO_BIT);
        rd(`OFS_IO_DATA, 32'h27);
        rd(`OFS_FLAGS, 32'h5A);
        $display("io bit test done");
        // ****************
        // shifts, carry out and upper flags kept
        // ****************
        wr(`OFS_GPR_ADDR, 32'h3, 1'b0);
        wr(`OFS_GPR_DATA, 32'h81, 1'b0);
        wr(`OFS_FLAGS, 32'hC0, 1'b0);
        run({23'h0, 5'h03, 4'h7}, `CYC_SHIFT);
        rd(`OFS_GPR_DATA, 32'h02);
        rd(`OFS_FLAGS, 32'hC9);
        run({23'h0, 5'h03, 4'h8}, `CYC_SHIFT);
        rd(`OFS_GPR_DATA, 32'h01);
        rd(`OFS_FLAGS, 32'hC0);
        run({23'h0, 5'h03, 4'h8}, `CYC_SHIFT);
        rd(`OFS_GPR_DATA, 32'h00);
        rd(`OFS_FLAGS, 32'hCB);
        $display("shift test done");
        // refused accesses leave no trace
        wr(`OFS_STATUS, 32'h1, 1'b1);
        wr(8'h20, 32'h1, 1'b1);
        wr(`OFS_INSTR, 32'h9, 1'b1);
        rd(`OFS_INSTR, 32'h38);
        rd(`OFS_FLAGS, 32'hCB);
        $display("refusal test done");
        print_verdict;
    end
endmodule : flag_branch_bitio_shift_exec_test

// File: mem_if.sv
// Purpose: port bundle of one byte-wide memory
// Assumes: one write and one registered read per clock
// Notes:   user drives address and write side, memory returns read data
`timescale 1ns/1ps
interface mem_if #(
    parameter int AW = 5
);
    logic          we;
    logic [AW-1:0] waddr;
    logic [7:0]    wdata;
    logic [AW-1:0] raddr;
    logic [7:0]    rdata;

    modport user (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : mem_if
